// ==== dual_event_counters.sv ====
// two 40-bit event counters with their configuration and access logic
`timescale 1ns/1ps

module dual_event_counters (
  input  wire logic        sys_clk_in,
  input  wire logic        rstn_in,
  input  wire logic        bus_clk_in,
  input  wire logic [1:0]  cpl_in,
  input  wire logic        user_read_permit_in,
  input  wire logic        msr_wr_in,
  input  wire logic        msr_rd_in,
  input  wire logic [1:0]  msr_sel_in,
  input  wire logic [63:0] msr_wdata_in,
  output logic      [63:0] msr_rdata_out,
  output logic             msr_ack_out,
  output logic             msr_fault_out,
  input  wire logic        pmc_rd_in,
  input  wire logic        pmc_sel_in,
  output logic      [39:0] pmc_rdata_out,
  output logic             pmc_ack_out,
  output logic             pmc_fault_out,
  input  wire logic [2:0]  evt_count_zero_in,
  input  wire logic [2:0]  evt_count_one_in,
  input  wire logic        evt_duration_zero_in,
  input  wire logic        evt_duration_one_in,
  output logic      [15:0] event_select_zero_out,
  output logic      [15:0] event_select_one_out,
  output logic             monitor_pin_zero_out,
  output logic             monitor_pin_one_out,
  output logic             perf_irq_out
);

  localparam int CW = dual_event_counters_pkg::CFG_W;
  localparam int NW = dual_event_counters_pkg::CNT_W;
  localparam int EW = dual_event_counters_pkg::EVT_W;

  // ---------------------------------------------------------------
  // functions
  // ---------------------------------------------------------------
  // threshold comparison and privilege filter, shared by both counters
  function automatic logic cond_met(input logic [CW-1:0] cfg,
                                    input logic [EW-1:0] cnt);
    logic [7:0] thr;
    logic [7:0] cnt8;
    thr  = cfg[dual_event_counters_pkg::THRESHOLD_MSB:
               dual_event_counters_pkg::THRESHOLD_LSB];
    cnt8 = {5'h00, cnt};
    if (thr == 8'h00)
      cond_met = (cnt != 3'h0);
    else if (cfg[dual_event_counters_pkg::THRESHOLD_INVERT_BIT])
      cond_met = (cnt8 < thr);
    else
      cond_met = (cnt8 >= thr);
  endfunction

  function automatic logic priv_ok(input logic [CW-1:0] cfg,
                                   input logic [1:0] cpl);
    if (cpl == dual_event_counters_pkg::CPL_KERNEL)
      priv_ok = cfg[dual_event_counters_pkg::KERNEL_LEVEL_FLAG_BIT];
    else
      priv_ok = cfg[dual_event_counters_pkg::USER_LEVEL_FLAG_BIT];
  endfunction

  // ---------------------------------------------------------------
  // declarations
  // ---------------------------------------------------------------
  logic [CW-1:0] cfg_reg     [2];
  logic [NW-1:0] cnt_reg     [2];
  logic [NW-1:0] cnt_next    [2];
  logic          prev_reg    [2];
  logic          qual        [2];
  logic          active      [2];
  logic [EW-1:0] inc_amount  [2];
  logic          ovf         [2];
  logic          pin_event   [2];
  logic [EW-1:0] evt_cnt     [2];
  logic          evt_dur     [2];
  logic          cfg_wr      [2];
  logic          cnt_wr      [2];
  logic          kernel;
  logic          msr_ok;
  logic [NW-1:0] load_value;
  logic          bus_sync1_reg;
  logic          bus_sync2_reg;
  logic          bus_prev_reg;
  logic          bus_edge;
  logic          irq_reg;
  logic [63:0]   msr_rdata_reg;
  logic          msr_ack_reg;
  logic          msr_fault_reg;
  logic [NW-1:0] pmc_rdata_reg;
  logic          pmc_ack_reg;
  logic          pmc_fault_reg;
  logic          pin_zero;
  logic          pin_one;

  assign evt_cnt[0] = evt_count_zero_in;
  assign evt_cnt[1] = evt_count_one_in;
  assign evt_dur[0] = evt_duration_zero_in;
  assign evt_dur[1] = evt_duration_one_in;

  // ---------------------------------------------------------------
  // register instruction decode
  // ---------------------------------------------------------------
  assign kernel = (cpl_in == dual_event_counters_pkg::CPL_KERNEL);
  assign msr_ok = kernel;
  assign cfg_wr[0] = msr_wr_in && msr_ok &&
    (msr_sel_in == dual_event_counters_pkg::SEL_EVENT_CONFIG_ZERO);
  assign cfg_wr[1] = msr_wr_in && msr_ok &&
    (msr_sel_in == dual_event_counters_pkg::SEL_EVENT_CONFIG_ONE);
  assign cnt_wr[0] = msr_wr_in && msr_ok &&
    (msr_sel_in == dual_event_counters_pkg::SEL_EVENT_COUNT_ZERO);
  assign cnt_wr[1] = msr_wr_in && msr_ok &&
    (msr_sel_in == dual_event_counters_pkg::SEL_EVENT_COUNT_ONE);

  // upper byte copies bit 31 so negative presets count up to overflow
  assign load_value = {{(NW-dual_event_counters_pkg::LOAD_W)
                        {msr_wdata_in[dual_event_counters_pkg::SIGN_BIT]}},
                       msr_wdata_in[dual_event_counters_pkg::LOAD_W-1:0]};

  // ---------------------------------------------------------------
  // per-counter qualification and increment
  // ---------------------------------------------------------------
  for (genvar i = 0; i < 2; i++)
  begin : g_cnt
    logic [NW:0] sum;
    logic [7:0]  thr;

    assign thr = cfg_reg[i][dual_event_counters_pkg::THRESHOLD_MSB:
                            dual_event_counters_pkg::THRESHOLD_LSB];

    // a fully cleared config stops its own counter; config zero's global enable bit gates both counters
    assign active[i] =
      cfg_reg[0][dual_event_counters_pkg::GLOBAL_ENABLE_BIT] &&
      (cfg_reg[i] != dual_event_counters_pkg::CFG_RESET);

    assign qual[i] = active[i] && priv_ok(cfg_reg[i], cpl_in) &&
                     cond_met(cfg_reg[i], evt_cnt[i]);

    always_comb
    begin
      inc_amount[i] = 3'h0;
      if (!qual[i])
        inc_amount[i] = 3'h0;
      else if (cfg_reg[i][dual_event_counters_pkg::EDGE_FLAG_BIT])
        inc_amount[i] = prev_reg[i] ? 3'h0 : 3'h1;
      else if (evt_dur[i])
        inc_amount[i] = 3'h1;
      else if (thr != 8'h00)
        inc_amount[i] = 3'h1;
      else
        inc_amount[i] = evt_cnt[i];
    end

    assign sum         = {1'b0, cnt_reg[i]} + {38'h0, inc_amount[i]};
    assign ovf[i]      = sum[NW];
    assign cnt_next[i] = sum[NW-1:0];

    assign pin_event[i] =
      cfg_reg[i][dual_event_counters_pkg::PIN_TOGGLE_SELECT_BIT] ?
      (inc_amount[i] != 3'h0) : ovf[i];

    // last qualified level, so held assertions count once
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        prev_reg[i] <= 1'b0;
      else
        prev_reg[i] <= qual[i];
    end

    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        cfg_reg[i] <= dual_event_counters_pkg::CFG_RESET;
      else if (cfg_wr[i])
        cfg_reg[i] <= msr_wdata_in[CW-1:0];
    end

    // a software load wins over a same-cycle increment
    always_ff @(posedge sys_clk_in or negedge rstn_in)
    begin
      if (!rstn_in)
        cnt_reg[i] <= dual_event_counters_pkg::CNT_RESET;
      else if (cnt_wr[i])
        cnt_reg[i] <= load_value;
      else
        cnt_reg[i] <= cnt_next[i];
    end
  end

  // ---------------------------------------------------------------
  // bus clock edge detection
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bus_sync1_reg <= 1'b0;
      bus_sync2_reg <= 1'b0;
      bus_prev_reg  <= 1'b0;
    end
    else
    begin
      bus_sync1_reg <= bus_clk_in;
      bus_sync2_reg <= bus_sync1_reg;
      bus_prev_reg  <= bus_sync2_reg;
    end
  end

  assign bus_edge = bus_sync2_reg && !bus_prev_reg;

  // ---------------------------------------------------------------
  // monitor pins
  // ---------------------------------------------------------------
  monitor_pin_pulser u_pin_zero (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .bus_edge_in (bus_edge),
    .event_in    (pin_event[0]),
    .pin_out     (pin_zero)
  );

  monitor_pin_pulser u_pin_one (
    .sys_clk_in  (sys_clk_in),
    .rstn_in     (rstn_in),
    .bus_edge_in (bus_edge),
    .event_in    (pin_event[1]),
    .pin_out     (pin_one)
  );

  assign monitor_pin_zero_out = pin_zero;
  assign monitor_pin_one_out  = pin_one;

  // ---------------------------------------------------------------
  // overflow interrupt request
  // ---------------------------------------------------------------
  // one-cycle request; the interrupt controller latches it
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      irq_reg <= 1'b0;
    else
      irq_reg <=
        (ovf[0] && cfg_reg[0][dual_event_counters_pkg::IRQ_ENABLE_BIT]) ||
        (ovf[1] && cfg_reg[1][dual_event_counters_pkg::IRQ_ENABLE_BIT]);
  end

  assign perf_irq_out = irq_reg;

  // ---------------------------------------------------------------
  // register instruction answer
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      msr_ack_reg   <= 1'b0;
      msr_fault_reg <= 1'b0;
    end
    else
    begin
      msr_ack_reg   <= msr_rd_in || msr_wr_in;
      msr_fault_reg <= (msr_rd_in || msr_wr_in) && !msr_ok;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      msr_rdata_reg <= 64'h0;
    else if (msr_rd_in && msr_ok)
    begin
      unique case (msr_sel_in)
        dual_event_counters_pkg::SEL_EVENT_CONFIG_ZERO:
          msr_rdata_reg <= {32'h0, cfg_reg[0]};
        dual_event_counters_pkg::SEL_EVENT_CONFIG_ONE:
          msr_rdata_reg <= {32'h0, cfg_reg[1]};
        dual_event_counters_pkg::SEL_EVENT_COUNT_ZERO:
          msr_rdata_reg <= {24'h0, cnt_reg[0]};
        dual_event_counters_pkg::SEL_EVENT_COUNT_ONE:
          msr_rdata_reg <= {24'h0, cnt_reg[1]};
      endcase
    end
    else
      msr_rdata_reg <= 64'h0;
  end

  assign msr_rdata_out = msr_rdata_reg;
  assign msr_ack_out   = msr_ack_reg;
  assign msr_fault_out = msr_fault_reg;

  // ---------------------------------------------------------------
  // counter read instruction
  // ---------------------------------------------------------------
  // samples the live value with no wait on other traffic
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      pmc_ack_reg   <= 1'b0;
      pmc_fault_reg <= 1'b0;
      pmc_rdata_reg <= dual_event_counters_pkg::CNT_RESET;
    end
    else
    begin
      pmc_ack_reg   <= pmc_rd_in;
      pmc_fault_reg <= pmc_rd_in && !kernel &&
                       !user_read_permit_in;
      if (pmc_rd_in && (kernel || user_read_permit_in))
        pmc_rdata_reg <= cnt_reg[pmc_sel_in];
      else
        pmc_rdata_reg <= dual_event_counters_pkg::CNT_RESET;
    end
  end

  assign pmc_rdata_out = pmc_rdata_reg;
  assign pmc_ack_out   = pmc_ack_reg;
  assign pmc_fault_out = pmc_fault_reg;

  // ---------------------------------------------------------------
  // selection towards the event detection logic
  // ---------------------------------------------------------------
  assign event_select_zero_out =
    cfg_reg[0][dual_event_counters_pkg::UNIT_QUALIFIER_MSB:
               dual_event_counters_pkg::EVENT_CODE_LSB];
  assign event_select_one_out =
    cfg_reg[1][dual_event_counters_pkg::UNIT_QUALIFIER_MSB:
               dual_event_counters_pkg::EVENT_CODE_LSB];

endmodule // dual_event_counters

// ==== dual_event_counters_pkg.sv ====
// constants shared by the dual event counter files
package dual_event_counters_pkg;

  // ---------------------------------------------------------------
  // widths
  // ---------------------------------------------------------------
  localparam int CFG_W     = 32;
  localparam int CNT_W     = 40;
  localparam int LOAD_W    = 32;
  localparam int MSR_W     = 64;
  localparam int EVT_W     = 3;
  localparam int SEL_OUT_W = 16;

  // ---------------------------------------------------------------
  // register selects on the register instruction port
  // ---------------------------------------------------------------
  localparam logic [1:0] SEL_EVENT_CONFIG_ZERO = 2'h0;
  localparam logic [1:0] SEL_EVENT_CONFIG_ONE  = 2'h1;
  localparam logic [1:0] SEL_EVENT_COUNT_ZERO  = 2'h2;
  localparam logic [1:0] SEL_EVENT_COUNT_ONE   = 2'h3;

  // ---------------------------------------------------------------
  // event configuration fields
  // ---------------------------------------------------------------
  localparam int EVENT_CODE_LSB        = 0;
  localparam int EVENT_CODE_MSB        = 7;
  localparam int UNIT_QUALIFIER_LSB    = 8;
  localparam int UNIT_QUALIFIER_MSB    = 15;
  localparam int USER_LEVEL_FLAG_BIT   = 16;
  localparam int KERNEL_LEVEL_FLAG_BIT = 17;
  localparam int EDGE_FLAG_BIT         = 18;
  localparam int PIN_TOGGLE_SELECT_BIT = 19;
  localparam int IRQ_ENABLE_BIT        = 20;
  localparam int GLOBAL_ENABLE_BIT     = 22;
  localparam int THRESHOLD_INVERT_BIT  = 23;
  localparam int THRESHOLD_LSB         = 24;
  localparam int THRESHOLD_MSB         = 31;
  localparam int SIGN_BIT              = 31;

  // ---------------------------------------------------------------
  // reset values and the kernel privilege level
  // ---------------------------------------------------------------
  localparam logic [CFG_W-1:0] CFG_RESET = 32'h0000_0000;
  localparam logic [CNT_W-1:0] CNT_RESET = 40'h00_0000_0000;
  localparam logic [1:0]       CPL_KERNEL = 2'h0;

endpackage

// ==== monitor_pin_pulser.sv ====
// stretches core-clock events into one bus-clock pulse on a monitor pin
`timescale 1ns/1ps

module monitor_pin_pulser (
  input  wire logic sys_clk_in,
  input  wire logic rstn_in,
  input  wire logic bus_edge_in,
  input  wire logic event_in,
  output logic      pin_out
);

  logic pending_reg;
  logic pin_reg;

  // ---------------------------------------------------------------
  // pending event, a new event wins over the clear
  // ---------------------------------------------------------------
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pending_reg <= 1'b0;
    else if (event_in)
      pending_reg <= 1'b1;
    else if (bus_edge_in && !pin_reg)
      pending_reg <= 1'b0;
  end

  // ---------------------------------------------------------------
  // pin held from one bus edge to the next
  // ---------------------------------------------------------------
  // many core events between bus edges merge into one pulse
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      pin_reg <= 1'b0;
    else if (bus_edge_in)
      pin_reg <= !pin_reg && pending_reg;
  end

  assign pin_out = pin_reg;

endmodule // monitor_pin_pulser

// ==== dual_event_counters_assertions.sv ====
// port-level checks for the dual event counters
`timescale 1ns/1ps

module dual_event_counters_assertions (
  input wire logic        sys_clk_in,
  input wire logic        rstn_in,
  input wire logic        bus_clk_in,
  input wire logic [1:0]  cpl_in,
  input wire logic        user_read_permit_in,
  input wire logic        msr_wr_in,
  input wire logic        msr_rd_in,
  input wire logic [1:0]  msr_sel_in,
  input wire logic [63:0] msr_wdata_in,
  input wire logic [63:0] msr_rdata_out,
  input wire logic        msr_ack_out,
  input wire logic        msr_fault_out,
  input wire logic        pmc_rd_in,
  input wire logic [39:0] pmc_rdata_out,
  input wire logic        pmc_ack_out,
  input wire logic        pmc_fault_out,
  input wire logic [15:0] event_select_zero_out,
  input wire logic [15:0] event_select_one_out,
  input wire logic        monitor_pin_zero_out,
  input wire logic        perf_irq_out
);
  // ---------------------------------------------------------------
  // helper state
  // ---------------------------------------------------------------
  logic       bus_prev_reg;
  logic [3:0] since_rise_reg;
  logic [1:0] irq_en_reg;

  // pin edges may only follow a bus clock rise by a few core clocks
  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
    begin
      bus_prev_reg   <= 1'b0;
      since_rise_reg <= 4'hf;
    end
    else
    begin
      bus_prev_reg   <= bus_clk_in;
      if (bus_clk_in && !bus_prev_reg)
        since_rise_reg <= 4'h0;
      else if (since_rise_reg != 4'hf)
        since_rise_reg <= since_rise_reg + 4'h1;
    end
  end

  always_ff @(posedge sys_clk_in or negedge rstn_in)
  begin
    if (!rstn_in)
      irq_en_reg <= 2'h0;
    else if (msr_wr_in && cpl_in == 2'h0 && !msr_sel_in[1])
      irq_en_reg[msr_sel_in[0]] <=
        msr_wdata_in[dual_event_counters_pkg::IRQ_ENABLE_BIT];
  end

  // ---------------------------------------------------------------
  // properties
  // ---------------------------------------------------------------
  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (!rstn_in);

  sequence msr_req;
    msr_wr_in || msr_rd_in;
  endsequence

  sequence cfg_write(sel);
    msr_wr_in && cpl_in == 2'h0 && msr_sel_in == sel;
  endsequence

  a_msr_ack_timing:
    assert property (msr_req |=> msr_ack_out)
    else $error("register access not answered next cycle");
  a_msr_ack_cause:
    assert property (msr_ack_out |-> $past(msr_wr_in || msr_rd_in))
    else $error("register answer without request");
  a_msr_refused:
    assert property (msr_req ##0 cpl_in != 2'h0
                     |=> msr_fault_out && msr_rdata_out == 64'h0)
    else $error("register access allowed outside level zero");
  a_msr_kernel_ok:
    assert property (msr_req ##0 cpl_in == 2'h0 |=> !msr_fault_out)
    else $error("register access refused at level zero");
  a_cfg_zero_mirror:
    assert property (cfg_write(2'h0) |=>
                     event_select_zero_out == $past(msr_wdata_in[15:0]))
    else $error("event select zero not taken from config");
  a_cfg_one_mirror:
    assert property (cfg_write(2'h1) |=>
                     event_select_one_out == $past(msr_wdata_in[15:0]))
    else $error("event select one not taken from config");
  a_pmc_ack_timing:
    assert property (pmc_rd_in |=> pmc_ack_out)
    else $error("counter read not answered next cycle");
  a_pmc_refused:
    assert property (pmc_rd_in && cpl_in != 2'h0 && !user_read_permit_in
                     |=> pmc_fault_out && pmc_rdata_out == 40'h0)
    else $error("counter read allowed without permit");
  a_pmc_allowed:
    assert property (pmc_rd_in && (cpl_in == 2'h0 || user_read_permit_in)
                     |=> !pmc_fault_out)
    else $error("permitted counter read refused");
  a_pin_bus_aligned:
    assert property ($changed(monitor_pin_zero_out) |->
                     since_rise_reg <= 4'h4)
    else $error("monitor pin edge away from bus clock edge");
  a_irq_enabled:
    assert property (perf_irq_out |-> irq_en_reg != 2'h0)
    else $error("interrupt raised while not enabled");
endmodule // dual_event_counters_assertions

// ==== test_dual_event_counters.sv ====
// self-checking bench for the dual event counters
`timescale 1ns/1ps

module test_dual_event_counters;
  typedef struct packed {
    logic [7:0] f0, f1, thr;
    logic [2:0] cnt;
    logic       dur;
    logic [1:0] cpl;
    logic [7:0] n, e0, e1;
  } row_t;

  logic        sys_clk_in = 1'b0;
  logic        rstn_in = 1'b0;
  logic        bus_clk_in = 1'b0;
  logic [1:0]  cpl_in = 2'h0;
  logic        user_read_permit_in = 1'b0;
  logic        msr_wr_in = 1'b0;
  logic        msr_rd_in = 1'b0;
  logic [1:0]  msr_sel_in = 2'h0;
  logic [63:0] msr_wdata_in = 64'h0;
  logic        pmc_rd_in = 1'b0;
  logic        pmc_sel_in = 1'b0;
  logic [2:0]  evt_count_in = 3'h0;
  logic        evt_duration_in = 1'b0;
  logic [63:0] msr_rdata_out;
  logic [39:0] pmc_rdata_out;
  logic [15:0] event_select_zero_out, event_select_one_out;
  logic        msr_ack_out, msr_fault_out, pmc_ack_out, pmc_fault_out;
  logic        monitor_pin_zero_out, monitor_pin_one_out, perf_irq_out;
  logic [2:0]  bus_div = 3'h0;
  logic [39:0] sum;
  logic [31:0] rv;
  logic [64:0] mq[$], pq[$];
  row_t        r;
  int          fails = 0, comparisons = 0, seed = 85;
  int          pin_hi = 0, pin1_hi = 0, irq_hits = 0, hi0, hi1, ir0;

  row_t rows[14] = '{
    '{8'h42, 8'h02, 8'h00, 3'h3, 1'b0, 2'h0, 8'h05, 8'h0f, 8'h0f},
    '{8'h42, 8'h02, 8'h00, 3'h3, 1'b0, 2'h2, 8'h05, 8'h00, 8'h00},
    '{8'h41, 8'h01, 8'h00, 3'h2, 1'b0, 2'h1, 8'h04, 8'h08, 8'h08},
    '{8'h43, 8'h03, 8'h00, 3'h1, 1'b0, 2'h3, 8'h06, 8'h06, 8'h06},
    '{8'h46, 8'h06, 8'h00, 3'h2, 1'b0, 2'h0, 8'h05, 8'h01, 8'h01},
    '{8'h42, 8'h02, 8'h00, 3'h2, 1'b1, 2'h0, 8'h05, 8'h05, 8'h05},
    '{8'h42, 8'h02, 8'h02, 3'h3, 1'b0, 2'h0, 8'h04, 8'h04, 8'h04},
    '{8'h42, 8'h02, 8'h04, 3'h3, 1'b0, 2'h0, 8'h04, 8'h00, 8'h00},
    '{8'hc1, 8'h81, 8'h02, 3'h1, 1'b0, 2'h3, 8'h07, 8'h07, 8'h07},
    '{8'hc1, 8'h81, 8'h02, 3'h3, 1'b0, 2'h3, 8'h07, 8'h00, 8'h00},
    '{8'hc2, 8'h82, 8'h00, 3'h3, 1'b0, 2'h0, 8'h03, 8'h09, 8'h09},
    '{8'h02, 8'h02, 8'h00, 3'h3, 1'b0, 2'h0, 8'h04, 8'h00, 8'h00},
    '{8'h42, 8'h00, 8'h00, 3'h2, 1'b0, 2'h0, 8'h03, 8'h06, 8'h00},
    '{8'h00, 8'h00, 8'h00, 3'h2, 1'b0, 2'h0, 8'h03, 8'h00, 8'h00}
  };

  dual_event_counters uut (
    .sys_clk_in, .rstn_in, .bus_clk_in, .cpl_in, .user_read_permit_in,
    .msr_wr_in, .msr_rd_in, .msr_sel_in, .msr_wdata_in, .msr_rdata_out,
    .msr_ack_out, .msr_fault_out, .pmc_rd_in, .pmc_sel_in, .pmc_rdata_out,
    .pmc_ack_out, .pmc_fault_out, .evt_count_zero_in(evt_count_in),
    .evt_count_one_in(evt_count_in), .evt_duration_zero_in(evt_duration_in),
    .evt_duration_one_in(evt_duration_in), .event_select_zero_out,
    .event_select_one_out, .monitor_pin_zero_out, .monitor_pin_one_out,
    .perf_irq_out
  );

  // ---------------------------------------------------------------
  // clocks, observers and helpers
  // ---------------------------------------------------------------
  always #4 sys_clk_in = ~sys_clk_in;

  // bus clock at one eighth of the core rate
  always @(posedge sys_clk_in)
  begin
    bus_div <= bus_div + 3'h1;
    bus_clk_in <= bus_div[2];
    pin_hi <= pin_hi + int'(monitor_pin_zero_out);
    pin1_hi <= pin1_hi + int'(monitor_pin_one_out);
    irq_hits <= irq_hits + int'(perf_irq_out);
    if (msr_ack_out === 1'b1)
      check({msr_fault_out, msr_rdata_out}, mq.pop_front());
    if (pmc_ack_out === 1'b1)
      check({pmc_fault_out, 24'h0, pmc_rdata_out}, pq.pop_front());
  end

  task automatic check(input logic [64:0] seen, input logic [64:0] want);
    comparisons++;
    if (seen !== want)
    begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, want);
    end
  endtask

  task automatic print_verdict;
    $display("comparisons %0d, fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic msr(input logic w, input logic [1:0] s,
                     input logic [63:0] d, input logic [1:0] c,
                     input logic [64:0] e);
    @(posedge sys_clk_in);
    msr_wr_in <= w;
    msr_rd_in <= !w;
    msr_sel_in <= s;
    msr_wdata_in <= d;
    cpl_in <= c;
    mq.push_back(e);
    @(posedge sys_clk_in);
    msr_wr_in <= 1'b0;
    msr_rd_in <= 1'b0;
    cpl_in <= 2'h0;
  endtask

  task automatic wr(input logic [1:0] s, input logic [63:0] d);
    msr(1'b1, s, d, 2'h0, 65'h0);
  endtask

  task automatic pmc(input logic s, input logic [1:0] c, input logic p,
                     input logic [64:0] e);
    @(posedge sys_clk_in);
    pmc_rd_in <= 1'b1;
    pmc_sel_in <= s;
    cpl_in <= c;
    user_read_permit_in <= p;
    pq.push_back(e);
    @(posedge sys_clk_in);
    pmc_rd_in <= 1'b0;
    cpl_in <= 2'h0;
  endtask

  task automatic events(input row_t x);
    @(posedge sys_clk_in);
    evt_count_in <= x.cnt;
    evt_duration_in <= x.dur;
    cpl_in <= x.cpl;
    repeat (x.n) @(posedge sys_clk_in);
    evt_count_in <= 3'h0;
    evt_duration_in <= 1'b0;
    cpl_in <= 2'h0;
  endtask

  // an all-zero flag byte means a fully cleared config
  function automatic logic [63:0] cfg(input logic [7:0] thr,
                                      input logic [7:0] f);
    return (f == 8'h0) ? 64'h0 : {32'h0, thr, f, 16'h5aa5};
  endfunction

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge sys_clk_in);
    rstn_in <= 1'b1;
    wr(2'h0, cfg(8'h00, 8'h40));
    msr(1'b0, 2'h0, 64'h0, 2'h0, {1'b0, cfg(8'h00, 8'h40)});
    check({49'h0, event_select_zero_out}, 65'h5aa5);
    msr(1'b1, 2'h0, 64'h0, 2'h3, {1'b1, 64'h0});
    msr(1'b0, 2'h0, 64'h0, 2'h1, {1'b1, 64'h0});
    msr(1'b0, 2'h0, 64'h0, 2'h0, {1'b0, cfg(8'h00, 8'h40)});
    foreach (rows[i])
    begin
      wr(2'h2, 64'h0);
      wr(2'h3, 64'h0);
      wr(2'h1, cfg(rows[i].thr, rows[i].f1));
      wr(2'h0, cfg(rows[i].thr, rows[i].f0));
      events(rows[i]);
      pmc(1'b0, 2'h0, 1'b0, {57'h0, rows[i].e0});
      pmc(1'b1, 2'h0, 1'b0, {57'h0, rows[i].e1});
    end
    wr(2'h2, 64'hffff_ffff_8000_0000);
    msr(1'b0, 2'h2, 64'h0, 2'h0, 65'h00ff_8000_0000);
    wr(2'h3, 64'hffff_ffff_7fff_ffff);
    msr(1'b0, 2'h3, 64'h0, 2'h0, 65'h7fff_ffff);
    pmc(1'b1, 2'h3, 1'b1, 65'h7fff_ffff);
    pmc(1'b1, 2'h3, 1'b0, {1'b1, 64'h0});
    // random per-cycle event counts
    wr(2'h2, 64'h0);
    wr(2'h0, cfg(8'h00, 8'h42));
    sum = 40'h0;
    repeat (12)
    begin
      @(posedge sys_clk_in);
      rv = $random(seed);
      evt_count_in <= rv[2:0];
      sum = sum + {37'h0, rv[2:0]};
    end
    @(posedge sys_clk_in);
    evt_count_in <= 3'h0;
    pmc(1'b0, 2'h0, 1'b0, {25'h0, sum});
    // monitor pin per increment, then overflow with interrupt
    r = '{8'h0, 8'h0, 8'h0, 3'h1, 1'b0, 2'h0, 8'h01, 8'h0, 8'h0};
    wr(2'h0, cfg(8'h00, 8'h4a));
    hi0 = pin_hi;
    hi1 = pin1_hi;
    events(r);
    repeat (40) @(posedge sys_clk_in);
    check(65'(pin_hi - hi0), 65'h8);
    check(65'(pin1_hi - hi1), 65'h0);
    wr(2'h2, 64'hffff_ffff);
    wr(2'h3, 64'hffff_ffff);
    wr(2'h1, cfg(8'h00, 8'h12));
    wr(2'h0, cfg(8'h00, 8'h42));
    hi0 = pin_hi;
    hi1 = pin1_hi;
    ir0 = irq_hits;
    events(r);
    repeat (40) @(posedge sys_clk_in);
    check(65'(pin_hi - hi0), 65'h8);
    check(65'(irq_hits - ir0), 65'h1);
    check(65'(pin1_hi - hi1), 65'h8);
    events(r);
    repeat (40) @(posedge sys_clk_in);
    check(65'(pin_hi - hi0), 65'h8);
    check(65'(pin1_hi - hi1), 65'h8);
    pmc(1'b0, 2'h0, 1'b0, 65'h1);
    pmc(1'b1, 2'h0, 1'b0, 65'h1);
    repeat (5) @(posedge sys_clk_in);
    check(65'(mq.size() + pq.size()), 65'h0);
    print_verdict();
  end

  // the whole run needs well under two thousand cycles
  initial
  begin
    repeat (5000) @(posedge sys_clk_in);
    fails++;
    print_verdict();
  end
endmodule // test_dual_event_counters

bind dual_event_counters dual_event_counters_assertions checker_i (
  .sys_clk_in, .rstn_in, .bus_clk_in, .cpl_in, .user_read_permit_in,
  .msr_wr_in, .msr_rd_in, .msr_sel_in, .msr_wdata_in, .msr_rdata_out,
  .msr_ack_out, .msr_fault_out, .pmc_rd_in, .pmc_rdata_out, .pmc_ack_out,
  .pmc_fault_out, .event_select_zero_out, .event_select_one_out,
  .monitor_pin_zero_out, .perf_irq_out
);
